// [common/fifo_defs.svh]
`ifndef FIFO_DEFS_SVH
`define FIFO_DEFS_SVH

// Default memory geometry
`define FIFO_ADDR_W 18
`define FIFO_DATA_W 9

// Offset defaults latched at reset
`define OFS_SERIAL_DEFAULT 10'h3FF
`define OFS_PARALLEL_DEFAULT 10'h07F

// Parallel offset byte sequence, last index before wrap and first full offset byte
`define OFS_LAST_BYTE 3'h5
`define OFS_FIRST_FULL_BYTE 3'h3

// Flag pipeline depths
`define STD_EMPTY_STAGES 2
`define FALL_THROUGH_MODE_READY_STAGES 3
`define FULL_STAGES 2

// Register map, byte addresses
`define REG_EMPTY_OFS 12'h000
`define REG_FULL_OFS 12'h004
`define REG_STATUS 12'h008
`define REG_COUNT 12'h00C

// Status register bit positions
`define ST_EMPTY_BIT 0
`define ST_FULL_BIT 1
`define ST_AEMPTY_BIT 2
`define ST_AFULL_BIT 3
`define ST_HALF_BIT 4
`define ST_FALL_THROUGH_MODE_BIT 5
`define ST_SERIAL_BIT 6

`endif

// [common/fifo_pkg.sv]
package fifo_pkg;

    typedef struct packed {
        logic emptyFlagN;
        logic fullFlagN;
        logic almostEmptyN;
        logic almostFullN;
        logic halfFullN;
    } flags_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

endpackage

// [design/dual_clock_fifo_flag_logic.sv]
// What this block does
// RULE1 - Mode pin sampled at reset picks standard or fall-through; held until next reset
// RULE2 - Standard mode: every word, first included, needs read enable low
// RULE3 - Fall-through: first word reaches outputs three edges after write, no read enable
// RULE4 - Word stored on each edge with write enable low and room left
// RULE5 - Standard empty flag rises after first write, falls after last read, blocks reads
// RULE6 - Standard almost-empty low for 0..n words, high from n+1
// RULE7 - Standard half-full low from half depth plus one words
// RULE8 - Standard almost-full low from depth minus m words
// RULE9 - Standard full flag low at depth, blocks writes; first read clears it
// RULE10 - Standard empty and full flags each pass two register stages
// RULE11 - Fall-through ready low once data valid, high after last read, reads ignored
// RULE12 - Fall-through almost-empty low for 0..n+1 words, high from n+2
// RULE13 - Fall-through half-full low from half depth plus two words
// RULE14 - Fall-through almost-full low from depth plus one minus m
// RULE15 - Fall-through capacity counts output register; input-ready high at depth plus one
// RULE16 - Fall-through output-ready three stages, input-ready two stages
// RULE17 - Load pin at reset picks serial or parallel loading and offset defaults
// RULE18 - Offsets read back only through the parallel read sequence; the code also returns them over APB at REG_EMPTY_OFS and REG_FULL_OFS
// RULE19 - Offsets may be reprogrammed any time after reset
// RULE20 - Draining releases almost-full and half-full at the filling thresholds
// RULE21 - Parallel load walks six offset bytes then wraps
// RULE22 - Serial load shifts one bit per edge, empty LSB first to full MSB
// RULE23 - Reset points both offset byte pointers at empty offset low byte
// RULE24 - Pointers cross as Gray code; flags computed on their own side
// RULE25 - Offset registers are as wide as the memory address
//
// The implementer's own choices: register access over APB and the register offsets.
`include "fifo_defs.svh"

module dual_clock_fifo_flag_logic #(
    parameter int ADDR_W = `FIFO_ADDR_W,
    parameter int DATA_W = `FIFO_DATA_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic modeSelectSerialIn,
    input wire logic offsetLoadN,
    input wire logic serialEnableN,
    input wire logic wrEnN,
    input wire logic [DATA_W-1:0] dataIn,
    input wire logic rdEnN,
    output logic [DATA_W-1:0] dataOut,
    output fifo_pkg::flags_t flags,
    input wire fifo_pkg::apb_req_t apbReq,
    output fifo_pkg::apb_rsp_t apbRsp
);

    localparam int OFS_W = ADDR_W; // [RULE25]
    localparam int PW = ADDR_W + 1;
    localparam int CW = ADDR_W + 2;
    localparam logic [CW-1:0] DEPTH_C = CW'(1) << ADDR_W;
    localparam logic [CW-1:0] HALF_C = DEPTH_C >> 1;

    typedef struct packed {
        logic fall_through_mode;
        logic serialLd;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [PW-1:0] wrGrayS1;
        logic [PW-1:0] wrGrayS2;
        logic [PW-1:0] rdGrayS1;
        logic [PW-1:0] rdGrayS2;
        logic [DATA_W-1:0] dataOut;
        logic ovalid;
        logic [2:0] outPipe;
        logic [1:0] inPipe;
        logic paeN;
        logic pafN;
        logic hfN;
        logic [OFS_W-1:0] emptyOfs;
        logic [OFS_W-1:0] fullOfs;
        logic [2:0] ofsWrPtr;
        logic [2:0] ofsRdPtr;
        logic [31:0] prdata;
        logic pslverr;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    logic [PW-1:0] wrSyncBin;
    logic [PW-1:0] rdSyncBin;
    logic [PW-1:0] rdCount;
    logic [PW-1:0] wrCount;
    logic [CW-1:0] totR;
    logic [CW-1:0] totW;
    logic wrFull;
    logic rdEmpty;
    logic wrDo;
    logic rdDo;
    logic pWr;
    logic pRd;
    logic sShift;
    logic apbSetup;
    logic apbAccess;
    logic [DATA_W-1:0] memRd;

    function automatic logic [PW-1:0] toGray(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PW-1:0] fromGray(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // Byte lane of a six-step offset pointer
    function automatic logic [1:0] laneOf(input logic [2:0] p);
        return (p >= `OFS_FIRST_FULL_BYTE) ? 2'(p - `OFS_FIRST_FULL_BYTE) : p[1:0];
    endfunction

    function automatic logic [OFS_W-1:0] putByte(input logic [OFS_W-1:0] v,
                                                 input logic [1:0] lane,
                                                 input logic [7:0] d);
        logic [23:0] t;
        t = 24'(v);
        t[lane*8 +: 8] = d;
        return t[OFS_W-1:0];
    endfunction

    function automatic logic [7:0] getByte(input logic [OFS_W-1:0] v,
                                           input logic [1:0] lane);
        logic [23:0] t;
        t = 24'(v);
        return t[lane*8 +: 8];
    endfunction

    // Each side works only from the other side's Gray pointer after two stages
    always_comb begin
        wrSyncBin = fromGray(st_r.wrGrayS2); // [RULE24]
        rdSyncBin = fromGray(st_r.rdGrayS2);
        rdCount = wrSyncBin - st_r.rdPtr;
        wrCount = st_r.wrPtr - rdSyncBin;
        totR = CW'(rdCount) + CW'(st_r.ovalid);
        totW = CW'(wrCount) + CW'(st_r.ovalid);
        wrFull = (CW'(wrCount) == DEPTH_C);
        rdEmpty = (rdCount == '0);
        memRd = mem[st_r.rdPtr[ADDR_W-1:0]];
        apbSetup = apbReq.psel && !apbReq.penable;
        apbAccess = apbReq.psel && apbReq.penable;
    end

    // Port decode follows the load/enable truth table
    always_comb begin
        wrDo = offsetLoadN && !wrEnN && !wrFull; // [RULE4] [RULE9] [RULE15]
        pWr = !offsetLoadN && !wrEnN && !st_r.serialLd; // [RULE21]
        sShift = !offsetLoadN && !serialEnableN && wrEnN && st_r.serialLd; // [RULE22]
        pRd = !offsetLoadN && !rdEnN && wrEnN; // [RULE18]
        if (st_r.fall_through_mode) begin
            rdDo = !rdEmpty && (!st_r.ovalid || (offsetLoadN && !rdEnN)); // [RULE3]
        end else begin
            rdDo = offsetLoadN && !rdEnN && !rdEmpty; // [RULE2] [RULE5]
        end
    end

    always_comb begin
        logic [OFS_W-1:0] def;
        logic [2*OFS_W-1:0] shiftReg;
        def = '0;
        shiftReg = '0;
        st_nxt = st_r;
        if (reset) begin
            st_nxt = '0;
            st_nxt.fall_through_mode = modeSelectSerialIn; // [RULE1]
            st_nxt.serialLd = offsetLoadN; // [RULE17]
            def = offsetLoadN ? OFS_W'(`OFS_SERIAL_DEFAULT) : OFS_W'(`OFS_PARALLEL_DEFAULT);
            st_nxt.emptyOfs = def;
            st_nxt.fullOfs = def;
            st_nxt.outPipe = modeSelectSerialIn ? 3'h7 : 3'h0;
            st_nxt.inPipe = modeSelectSerialIn ? 2'h0 : 2'h3;
            st_nxt.pafN = 1'b1;
            st_nxt.hfN = 1'b1;
            st_nxt.ofsWrPtr = 3'h0; // [RULE23]
            st_nxt.ofsRdPtr = 3'h0;
        end else begin
            if (wrDo) begin
                st_nxt.wrPtr = st_r.wrPtr + PW'(1);
            end
            st_nxt.wrGrayS1 = toGray(st_r.wrPtr); // [RULE24]
            st_nxt.wrGrayS2 = st_r.wrGrayS1;
            st_nxt.rdGrayS1 = toGray(st_r.rdPtr);
            st_nxt.rdGrayS2 = st_r.rdGrayS1;

            if (rdDo) begin
                st_nxt.rdPtr = st_r.rdPtr + PW'(1);
                st_nxt.dataOut = memRd;
                st_nxt.ovalid = st_r.fall_through_mode;
            end else if (st_r.fall_through_mode && st_r.ovalid && offsetLoadN && !rdEnN) begin
                st_nxt.ovalid = 1'b0; // [RULE11]
            end else if (pRd) begin
                st_nxt.dataOut = DATA_W'(getByte(
                    (st_r.ofsRdPtr >= `OFS_FIRST_FULL_BYTE) ? st_r.fullOfs : st_r.emptyOfs,
                    laneOf(st_r.ofsRdPtr))); // [RULE18]
            end
            if (pRd) begin
                st_nxt.ofsRdPtr = (st_r.ofsRdPtr == `OFS_LAST_BYTE) ? 3'h0
                                  : st_r.ofsRdPtr + 3'h1;
            end

            // Empty side: standard flag uses two stages, ready flag three
            st_nxt.outPipe[0] = st_r.fall_through_mode ? !st_nxt.ovalid : !rdEmpty; // [RULE5] [RULE11]
            st_nxt.outPipe[2:1] = st_r.outPipe[1:0]; // [RULE10] [RULE16]
            st_nxt.inPipe[0] = st_r.fall_through_mode ? wrFull : !wrFull; // [RULE9] [RULE15]
            st_nxt.inPipe[1] = st_r.inPipe[0]; // [RULE10] [RULE16]

            // Same thresholds both ways, so draining mirrors filling
            st_nxt.paeN = totR > (CW'(st_r.emptyOfs) + CW'(st_r.fall_through_mode)); // [RULE6] [RULE12]
            st_nxt.hfN = !(totW >= HALF_C + CW'(1) + CW'(st_r.fall_through_mode)); // [RULE7] [RULE13] [RULE20]
            st_nxt.pafN = !(totW + CW'(st_r.fullOfs)
                            >= DEPTH_C + CW'(st_r.fall_through_mode)); // [RULE8] [RULE14] [RULE20]

            if (pWr) begin
                if (st_r.ofsWrPtr >= `OFS_FIRST_FULL_BYTE) begin
                    st_nxt.fullOfs = putByte(st_r.fullOfs, laneOf(st_r.ofsWrPtr),
                                             dataIn[7:0]); // [RULE21]
                end else begin
                    st_nxt.emptyOfs = putByte(st_r.emptyOfs, laneOf(st_r.ofsWrPtr),
                                              dataIn[7:0]); // [RULE21]
                end
                st_nxt.ofsWrPtr = (st_r.ofsWrPtr == `OFS_LAST_BYTE) ? 3'h0
                                  : st_r.ofsWrPtr + 3'h1;
            end
            if (sShift) begin
                // Right shift so the first bit in ends at the empty offset LSB
                shiftReg = {modeSelectSerialIn, st_r.fullOfs, st_r.emptyOfs[OFS_W-1:1]};
                st_nxt.fullOfs = shiftReg[2*OFS_W-1:OFS_W]; // [RULE22]
                st_nxt.emptyOfs = shiftReg[OFS_W-1:0];
            end

            // Bus: read data latched in setup, so access completes with no wait
            if (apbSetup) begin
                st_nxt.pslverr = 1'b0;
                unique case (apbReq.paddr)
                    `REG_EMPTY_OFS: st_nxt.prdata = 32'(st_r.emptyOfs);
                    `REG_FULL_OFS: st_nxt.prdata = 32'(st_r.fullOfs);
                    `REG_STATUS: begin
                        st_nxt.prdata = '0;
                        st_nxt.prdata[`ST_EMPTY_BIT] = flags.emptyFlagN;
                        st_nxt.prdata[`ST_FULL_BIT] = flags.fullFlagN;
                        st_nxt.prdata[`ST_AEMPTY_BIT] = st_r.paeN;
                        st_nxt.prdata[`ST_AFULL_BIT] = st_r.pafN;
                        st_nxt.prdata[`ST_HALF_BIT] = st_r.hfN;
                        st_nxt.prdata[`ST_FALL_THROUGH_MODE_BIT] = st_r.fall_through_mode;
                        st_nxt.prdata[`ST_SERIAL_BIT] = st_r.serialLd;
                    end
                    `REG_COUNT: st_nxt.prdata = 32'(totW);
                    default: begin
                        st_nxt.prdata = '0;
                        st_nxt.pslverr = 1'b1;
                    end
                endcase
            end
            // Bus write wins over a pin load in the same cycle
            if (apbAccess && apbReq.pwrite) begin
                if (apbReq.paddr == `REG_EMPTY_OFS) begin
                    st_nxt.emptyOfs = apbReq.pwdata[OFS_W-1:0]; // [RULE19]
                end else if (apbReq.paddr == `REG_FULL_OFS) begin
                    st_nxt.fullOfs = apbReq.pwdata[OFS_W-1:0]; // [RULE19]
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    // Storage has no reset; pointers alone say what is valid
    always_ff @(posedge clk) begin
        if (wrDo) begin
            mem[st_r.wrPtr[ADDR_W-1:0]] <= dataIn; // [RULE4]
        end
    end

    always_comb begin
        dataOut = st_r.dataOut;
        flags.emptyFlagN = st_r.fall_through_mode ? st_r.outPipe[2] : st_r.outPipe[1];
        flags.fullFlagN = st_r.inPipe[1];
        flags.almostEmptyN = st_r.paeN;
        flags.almostFullN = st_r.pafN;
        flags.halfFullN = st_r.hfN;
        apbRsp.prdata = st_r.prdata;
        apbRsp.pready = apbAccess;
        apbRsp.pslverr = apbAccess && st_r.pslverr;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_mode_hold;
        !$past(reset) |-> $stable(st_r.fall_through_mode) && $stable(st_r.serialLd);
    endproperty
    a_mode_hold: assert property (p_mode_hold) // [RULE1]
        else $error("timing mode changed outside reset");

    property p_write_advance;
        wrDo |=> st_r.wrPtr == $past(st_r.wrPtr) + PW'(1);
    endproperty
    a_write_advance: assert property (p_write_advance) // [RULE4]
        else $error("write pointer did not advance on write");

    property p_full_blocks;
        (CW'(wrCount) == DEPTH_C) |-> !wrDo ##1 st_r.inPipe[0] == st_r.fall_through_mode;
    endproperty
    a_full_blocks: assert property (p_full_blocks) // [RULE9]
        else $error("write accepted or full flag wrong when full");

    property p_std_empty_no_read;
        (!st_r.fall_through_mode && rdEmpty) |-> !rdDo;
    endproperty
    a_std_empty_no_read: assert property (p_std_empty_no_read) // [RULE5]
        else $error("standard read from empty buffer");

    property p_std_two_stage;
        !st_r.fall_through_mode && !$past(reset, 3) |-> flags.emptyFlagN == $past(!rdEmpty, 2);
    endproperty
    a_std_two_stage: assert property (p_std_two_stage) // [RULE10]
        else $error("empty flag not two stages behind");

    property p_fall_through_mode_three_stage;
        st_r.fall_through_mode && !$past(reset, 3) |-> flags.emptyFlagN == $past(!st_r.ovalid, 2);
    endproperty
    a_fall_through_mode_three_stage: assert property (p_fall_through_mode_three_stage) // [RULE16]
        else $error("ready flag not three stages behind");

    property p_fall_through;
        (st_r.fall_through_mode && !st_r.ovalid && !rdEmpty) |=> st_r.ovalid && $changed(st_r.rdPtr);
    endproperty
    a_fall_through: assert property (p_fall_through) // [RULE3]
        else $error("first word did not fall through");

    property p_std_almost_empty;
        !st_r.fall_through_mode |=> st_r.paeN == ($past(totR) > CW'($past(st_r.emptyOfs)));
    endproperty
    a_std_almost_empty: assert property (p_std_almost_empty) // [RULE6]
        else $error("almost-empty threshold wrong");

    property p_defaults;
        $past(reset) |-> st_r.emptyOfs == (st_r.serialLd ? OFS_W'(`OFS_SERIAL_DEFAULT)
                                                         : OFS_W'(`OFS_PARALLEL_DEFAULT));
    endproperty
    a_defaults: assert property (p_defaults) // [RULE17]
        else $error("offset default wrong after reset");

    property p_offset_wrap;
        (pWr && !apbAccess && st_r.ofsWrPtr == `OFS_LAST_BYTE) |=> st_r.ofsWrPtr == 3'h0;
    endproperty
    a_offset_wrap: assert property (p_offset_wrap) // [RULE21]
        else $error("offset byte pointer did not wrap");

    property p_std_half_full;
        !st_r.fall_through_mode |=> st_r.hfN == ($past(totW) < HALF_C + CW'(1));
    endproperty
    a_std_half_full: assert property (p_std_half_full) // [RULE7]
        else $error("half-full threshold wrong");

    property p_std_almost_full;
        !st_r.fall_through_mode |=> st_r.pafN == ($past(totW) + CW'($past(st_r.fullOfs)) < DEPTH_C);
    endproperty
    a_std_almost_full: assert property (p_std_almost_full) // [RULE8]
        else $error("almost-full threshold wrong");

    property p_fall_through_mode_last_read;
        (st_r.fall_through_mode && st_r.ovalid && rdEmpty && offsetLoadN && !rdEnN) |=> !st_r.ovalid;
    endproperty
    a_fall_through_mode_last_read: assert property (p_fall_through_mode_last_read) // [RULE11]
        else $error("last word not released on read");

    property p_serial_shift;
        (sShift && !apbAccess) |=> st_r.emptyOfs[OFS_W-1] == $past(st_r.fullOfs[0]);
    endproperty
    a_serial_shift: assert property (p_serial_shift) // [RULE22]
        else $error("serial offset bit did not move down");

    property p_reset_pointers;
        $past(reset) |-> st_r.ofsWrPtr == 3'h0 && st_r.ofsRdPtr == 3'h0;
    endproperty
    a_reset_pointers: assert property (p_reset_pointers) // [RULE23]
        else $error("offset byte pointers not at start after reset");

endmodule

// [testbench/fifo_stream_partner.sv]
module fifo_stream_partner #(
    parameter int DATA_W = 9
) (
    input wire logic clk,
    output logic wrEnN,
    output logic rdEnN,
    output logic [DATA_W-1:0] dataIn,
    output logic modeSelectSerialIn,
    output logic offsetLoadN,
    output logic serialEnableN
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        wrEnN = 1'b1;
        rdEnN = 1'b1;
        dataIn = '0;
        modeSelectSerialIn = 1'b0;
        offsetLoadN = 1'b1;
        serialEnableN = 1'b1;
    end

    // Released data lines show the inverse, so stale values never pass
    task push(input logic [DATA_W-1:0] d);
        @(posedge clk);
        wrEnN <= 1'b0;
        dataIn <= d;
        @(posedge clk);
        wrEnN <= 1'b1;
        dataIn <= ~d;
    endtask

    task pop();
        @(posedge clk);
        rdEnN <= 1'b0;
        @(posedge clk);
        rdEnN <= 1'b1;
    endtask

    task parRead();
        @(posedge clk);
        offsetLoadN <= 1'b0;
        rdEnN <= 1'b0;
        @(posedge clk);
        offsetLoadN <= 1'b1;
        rdEnN <= 1'b1;
    endtask

    task cfg(input logic f, input logic l);
        modeSelectSerialIn <= f;
        offsetLoadN <= l;
    endtask

    task parLoad(input logic [7:0] b);
        @(posedge clk);
        offsetLoadN <= 1'b0;
        wrEnN <= 1'b0;
        dataIn <= DATA_W'(b);
        @(posedge clk);
        offsetLoadN <= 1'b1;
        wrEnN <= 1'b1;
        dataIn <= ~DATA_W'(b);
    endtask

    task serLoad(input logic [15:0] v, input int nb);
        for (int i = 0; i < nb; i++) begin
            @(posedge clk);
            offsetLoadN <= 1'b0;
            serialEnableN <= 1'b0;
            modeSelectSerialIn <= v[i];
        end
        @(posedge clk);
        offsetLoadN <= 1'b1;
        serialEnableN <= 1'b1;
        modeSelectSerialIn <= ~v[nb-1];
    endtask
endmodule

// [testbench/testbench.sv]
`define CHK(nm, ex, got) \
    begin \
        n_tests++; \
        if ((got) !== (ex)) begin \
            error_cnt++; \
            $display("MISMATCH %s exp=%0h got=%0h", nm, ex, got); \
        end \
    end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // Small depth keeps every threshold reachable in a short run
    localparam int AW = 4;
    localparam int D = 1 << AW;
    localparam logic [31:0] MASK = 32'(D - 1);

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wrEnN, rdEnN, modeSelectSerialIn, offsetLoadN, serialEnableN;
    logic [8:0] dataIn, dataOut, e, w, last;
    fifo_pkg::flags_t flags;
    fifo_pkg::apb_req_t apbReq;
    fifo_pkg::apb_rsp_t apbRsp;
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 48;
    int n, m;
    logic fall_through_mode = 1'b0;
    logic rdPrev = 1'b0;
    logic [8:0] expQ[$];
    logic [31:0] rd;
    logic err;

    always #5 clk = ~clk;

    dual_clock_fifo_flag_logic #(.ADDR_W(AW)) dual_clock_fifo_flag_logic_i (
        .clk(clk), .reset(reset), .modeSelectSerialIn(modeSelectSerialIn),
        .offsetLoadN(offsetLoadN), .serialEnableN(serialEnableN), .wrEnN(wrEnN),
        .dataIn(dataIn), .rdEnN(rdEnN), .dataOut(dataOut), .flags(flags),
        .apbReq(apbReq), .apbRsp(apbRsp));

    fifo_stream_partner fifo_stream_partner_i (
        .clk(clk), .wrEnN(wrEnN), .rdEnN(rdEnN), .dataIn(dataIn),
        .modeSelectSerialIn(modeSelectSerialIn), .offsetLoadN(offsetLoadN),
        .serialEnableN(serialEnableN));

    // Standard mode shows the word one edge after the read; fall-through consumes the shown word
    always @(posedge clk) begin
        if ((!fall_through_mode && rdPrev) || (fall_through_mode && rdEnN === 1'b0 && offsetLoadN === 1'b1
                && flags.emptyFlagN === 1'b0)) begin
            if (expQ.size() == 0) begin
                error_cnt++;
                $display("MISMATCH dataOut exp=none got=%0h", dataOut);
            end else begin
                e = expQ.pop_front();
                `CHK("dataOut", e, dataOut)
            end
        end
        rdPrev <= !fall_through_mode && rdEnN === 1'b0 && offsetLoadN === 1'b1 && flags.emptyFlagN === 1'b1;
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        @(posedge clk);
        while (apbRsp.pready !== 1'b1) @(posedge clk);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
    endtask

    task automatic checkFlags(input int c);
        logic [4:0] x;
        if (!fall_through_mode) begin
            x = {c > 0, c < D, c > n, c < D - m, c < D / 2 + 1};
            `CHK("flags", x, flags)
        end else begin
            x = {c == 0, c >= D + 1, c > n + 1, c < D + 1 - m, c < D / 2 + 2};
            `CHK("flags", x, flags)
        end
    endtask

    task automatic runPhase(input logic ff, input logic ld);
        int cap;
        fall_through_mode = ff;
        cap = ff ? D + 1 : D;
        n = ld ? 3 : 2;
        m = ld ? 2 : 3;
        reset <= 1'b1;
        fifo_stream_partner_i.cfg(ff, ld);
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        fifo_stream_partner_i.cfg(1'b0, 1'b1);
        checkFlags(0);
        apb(1'b0, 12'h000, 32'h0);
        `CHK("emptyOfs", (ld ? 32'h3FF : 32'h07F) & MASK, rd)
        apb(1'b1, 12'h004, 32'h5);
        apb(1'b0, 12'h004, 32'h0);
        `CHK("fullOfs", 32'h5, rd)
        apb(1'b0, 12'h010, 32'h0);
        `CHK("unmapped", {1'b1, 32'h0}, {err, rd})
        if (ld) begin
            fifo_stream_partner_i.serLoad(16'h0023, 2 * AW);
        end else begin
            for (int i = 0; i < 6; i++) begin
                fifo_stream_partner_i.parLoad(i == 0 ? 8'h02 : (i == 3 ? 8'h03 : 8'h00));
            end
        end
        apb(1'b0, 12'h000, 32'h0);
        `CHK("emptyOfs", 32'(n), rd)
        apb(1'b0, 12'h004, 32'h0);
        `CHK("fullOfs", 32'(m), rd)
        // Pin read-back walks the six bytes from the empty low byte, then wraps
        for (int i = 0; i < 7; i++) begin
            fifo_stream_partner_i.parRead();
            @(posedge clk);
            `CHK("ofsByte", 9'(i % 6 == 0 ? n : (i % 6 == 3 ? m : 0)), dataOut)
        end
        apb(1'b0, 12'h008, 32'h0);
        `CHK("mode", {ld, ff}, rd[6:5])
        for (int k = 1; k <= cap; k++) begin
            w = 9'($random(seed));
            fifo_stream_partner_i.push(w);
            expQ.push_back(w);
            repeat (10) @(posedge clk);
            checkFlags(k);
            if (ff && k == 1) `CHK("fallThrough", w, dataOut)
        end
        // A write into a full buffer must be dropped, so it is never queued
        fifo_stream_partner_i.push(9'h1AA);
        repeat (10) @(posedge clk);
        checkFlags(cap);
        for (int k = cap; k > 0; k--) begin
            fifo_stream_partner_i.pop();
            repeat (10) @(posedge clk);
            checkFlags(k - 1);
        end
        last = dataOut;
        fifo_stream_partner_i.pop();
        repeat (10) @(posedge clk);
        `CHK("holdOnEmpty", last, dataOut)
        `CHK("leftover", 0, expQ.size())
    endtask

    task test_done();
        $display("Checks: %0d, mismatches: %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        apbReq = '0;
        runPhase(1'b0, 1'b0);
        runPhase(1'b1, 1'b1);
        test_done();
    end

    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        test_done();
    end
endmodule
